// >>> mpc_pkg.sv
// Purpose: shared constants and types for the multi-processor serial block
// Assumes: single 25 MHz clock, registers over a plain strobe port
// Notes:   register offsets are byte addresses of 32-bit words
package mpc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_CTRL_A = 8'h04;
  localparam logic [7:0] OFS_CTRL_B = 8'h08;
  localparam logic [7:0] OFS_BAUD   = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_CL = 8'h18;

  // control/status a field positions
  localparam int unsigned BIT_RXC    = 7;
  localparam int unsigned BIT_TXC    = 6;
  localparam int unsigned BIT_DRE    = 5;
  localparam int unsigned BIT_FE     = 4;
  localparam int unsigned BIT_DOUBLE = 1;
  localparam int unsigned BIT_AFM    = 0;

  // control b field positions
  localparam int unsigned BIT_TX_NINTH_BIT   = 0;
  localparam int unsigned BIT_STOP2  = 3;
  localparam int unsigned POS_CSZ    = 4;

  // character size codes
  localparam logic [2:0] CSZ_5 = 3'h0;
  localparam logic [2:0] CSZ_8 = 3'h3;
  localparam logic [2:0] CSZ_9 = 3'h7;

  // reset values
  localparam logic [2:0]  RST_CSZ  = 3'h3;
  localparam logic [11:0] RST_BAUD = 12'h000;

  // oversampling per bit
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;

  // interrupt event bit positions
  localparam int unsigned EV_RX   = 0;
  localparam int unsigned EV_TX   = 1;
  localparam int unsigned EV_FE   = 2;
  localparam int unsigned EV_W    = 3;

  typedef struct packed {
    logic       frame_type;  // 1: address frame
    logic [8:0] data;
    logic       stop_bad;
  } rx_frame_type;

  typedef enum logic [1:0] {
    LS_IDLE  = 2'b00,
    LS_START = 2'b01,
    LS_BITS  = 2'b10,
    LS_STOP  = 2'b11
  } line_state_type;

endpackage

// >>> mpc_uart.sv
// What this block does
// - address frame buffered, raises receive-complete flag
// - filter clear: every data frame buffered
// - filter set: data frames dropped; a low first stop still sets the frame-error event
// - transmitter and receiver share one size
// - divisor zero gives maximum exact rate
// - frame type is first stop or ninth bit
// - filter set: non-address frames never buffered
// - transmitter ignores the filter mode
//
// Purpose: serial receiver/transmitter with address-frame filtering
// Assumes: rx line is synchronous to clock_in; one-cycle bus strobes
// Notes:   writes to control a store only the filter and speed bits,
//          so a whole-register write clears the tx flag when bit 6 is one, unless a transmit ends in that cycle
`timescale 1ns/1ps
`default_nettype none

module mpc_uart #(
  parameter int unsigned BAUD_W = 12
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             irq_out
);

  // register state
  logic [8:0]        rx_buf_ff;
  logic              rxc_ff, txc_ff, fe_ff;
  logic              afm_ff, dbl_ff, tx_ninth_bit_ff, stop2_ff;
  logic [2:0]        csz_ff;
  logic [BAUD_W-1:0] baud_ff;
  logic [mpc_pkg::EV_W-1:0] irq_st_ff, irq_en_ff;
  logic [31:0]       rdata_ff;

  // bus decode
  wire wr_data = wr_in && (addr_in == mpc_pkg::OFS_DATA);
  wire wr_ca   = wr_in && (addr_in == mpc_pkg::OFS_CTRL_A);
  wire wr_cb   = wr_in && (addr_in == mpc_pkg::OFS_CTRL_B);
  wire wr_bd   = wr_in && (addr_in == mpc_pkg::OFS_BAUD);
  wire wr_en   = wr_in && (addr_in == mpc_pkg::OFS_IRQ_EN);
  wire wr_cl   = wr_in && (addr_in == mpc_pkg::OFS_IRQ_CL);
  wire rd_data = rd_in && (addr_in == mpc_pkg::OFS_DATA);

  // baud tick: one tick per oversample, clock/(divisor+1)
  logic [BAUD_W-1:0] pre_ff;
  wire tick = (pre_ff == '0);
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      pre_ff <= '0;
    else
      pre_ff <= tick ? baud_ff : pre_ff - 1'b1;
  end
  // oversample count per bit: 16 normal, 8 double
  wire [4:0] ovs = dbl_ff ? mpc_pkg::OVS_DOUBLE
                          : mpc_pkg::OVS_NORMAL;
  wire [3:0] nbits = (csz_ff == mpc_pkg::CSZ_9) ? 4'h9
                   : {2'b00, csz_ff[1:0]} + 4'h5;

  // receiver
  mpc_pkg::line_state_type rs_ff;
  logic [4:0] rs_cnt_ff;
  logic [3:0] rs_bit_ff;
  logic [8:0] rs_sh_ff;
  wire [4:0] half = {1'b0, ovs[4:1]};
  wire rs_mid = tick && (rs_cnt_ff == 5'h01);
  // frame type: ninth bit for 9-bit frames, else first stop
  wire is9 = (csz_ff == mpc_pkg::CSZ_9);
  wire [8:0] rs_data = is9 ? rs_sh_ff
                     : (rs_sh_ff >> (4'h9 - nbits));
  wire rx_ftype = is9 ? rs_sh_ff[8] : rxd_in;
  wire rx_done = (rs_ff == mpc_pkg::LS_STOP) && rs_mid;
  // drop non-address frames while filtering
  wire rx_keep = rx_done && (!afm_ff || rx_ftype);
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rs_ff     <= mpc_pkg::LS_IDLE;
      rs_cnt_ff <= '0;
      rs_bit_ff <= '0;
      rs_sh_ff  <= '0;
    end
    else
    begin
      unique case (rs_ff)
        mpc_pkg::LS_IDLE:
          if (!rxd_in)
          begin
            rs_ff     <= mpc_pkg::LS_START;
            rs_cnt_ff <= half;
          end
        mpc_pkg::LS_START:
          if (rs_mid)
          begin
            rs_ff     <= rxd_in ? mpc_pkg::LS_IDLE : mpc_pkg::LS_BITS;
            rs_cnt_ff <= ovs;
            rs_bit_ff <= '0;
          end
          else if (tick)
            rs_cnt_ff <= rs_cnt_ff - 5'h01;
        mpc_pkg::LS_BITS:
          if (rs_mid)
          begin
            rs_sh_ff  <= {rxd_in, rs_sh_ff[8:1]};
            rs_cnt_ff <= ovs;
            rs_bit_ff <= rs_bit_ff + 4'h1;
            if (rs_bit_ff == nbits - 4'h1)
              rs_ff <= mpc_pkg::LS_STOP;
          end
          else if (tick)
            rs_cnt_ff <= rs_cnt_ff - 5'h01;
        mpc_pkg::LS_STOP:
          if (rs_mid)
            rs_ff <= mpc_pkg::LS_IDLE;
          else if (tick)
            rs_cnt_ff <= rs_cnt_ff - 5'h01;
      endcase
    end
  end

  // transmitter, unaffected by the filter bit
  logic       tx_busy_ff, tx_pend_ff;
  logic [8:0] tx_hold_ff;
  logic [11:0] tx_sh_ff;
  logic [3:0] tx_left_ff;
  logic [4:0] tx_cnt_ff;
  wire tx_step = tx_busy_ff && tick && (tx_cnt_ff == 5'h01);
  wire tx_last = tx_step && (tx_left_ff == 4'h1);
  // frame: start, data bits, ninth bit if used, one or two stops
  wire [3:0] tx_len = nbits + (stop2_ff ? 4'h3 : 4'h2);
  wire [11:0] tx_frame = ({3'b111, tx_hold_ff} << 1)
                       | ({12{1'b1}} << (nbits + 4'h1));
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_busy_ff <= 1'b0;
      tx_pend_ff <= 1'b0;
      tx_hold_ff <= '0;
      tx_sh_ff   <= '1;
      tx_left_ff <= '0;
      tx_cnt_ff  <= '0;
    end
    else
    begin
      if (wr_data)
      begin
        tx_pend_ff <= 1'b1;
        tx_hold_ff <= {tx_ninth_bit_ff, wdata_in[7:0]};
      end
      if (!tx_busy_ff && tx_pend_ff && tick)
      begin
        tx_busy_ff <= 1'b1;
        tx_pend_ff <= 1'b0;
        tx_sh_ff   <= tx_frame;
        tx_left_ff <= tx_len;
        tx_cnt_ff  <= ovs;
      end
      else if (tx_step)
      begin
        tx_sh_ff   <= {1'b1, tx_sh_ff[11:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
        tx_cnt_ff  <= ovs;
        if (tx_last)
          tx_busy_ff <= 1'b0;
      end
      else if (tx_busy_ff && tick)
        tx_cnt_ff <= tx_cnt_ff - 5'h01;
    end
  end
  assign txd_out = tx_busy_ff ? tx_sh_ff[0] : 1'b1;

  // registers; hardware set beats software clear
  wire [mpc_pkg::EV_W-1:0] ev = {rx_done && !rxd_in, tx_last, rx_keep};
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_buf_ff <= '0;
      rxc_ff    <= 1'b0;
      txc_ff    <= 1'b0;
      fe_ff     <= 1'b0;
      afm_ff    <= 1'b0;
      dbl_ff    <= 1'b0;
      tx_ninth_bit_ff   <= 1'b0;
      stop2_ff  <= 1'b0;
      csz_ff    <= mpc_pkg::RST_CSZ;
      baud_ff   <= '0;
      irq_st_ff <= '0;
      irq_en_ff <= '0;
    end
    else
    begin
      if (rx_keep)
      begin
        rx_buf_ff <= rs_data;
        fe_ff     <= !rxd_in;
      end
      rxc_ff <= rx_keep || (rxc_ff && !rd_data);
      // tx flag cleared by writing one, set wins
      txc_ff <= tx_last
             || (txc_ff && !(wr_ca && wdata_in[mpc_pkg::BIT_TXC]));
      if (wr_ca)
      begin
        afm_ff <= wdata_in[mpc_pkg::BIT_AFM];
        dbl_ff <= wdata_in[mpc_pkg::BIT_DOUBLE];
      end
      if (wr_cb)
      begin
        tx_ninth_bit_ff  <= wdata_in[mpc_pkg::BIT_TX_NINTH_BIT];
        stop2_ff <= wdata_in[mpc_pkg::BIT_STOP2];
        csz_ff   <= wdata_in[mpc_pkg::POS_CSZ +: 3];
      end
      if (wr_bd)
        baud_ff <= wdata_in[BAUD_W-1:0];
      if (wr_en)
        irq_en_ff <= wdata_in[mpc_pkg::EV_W-1:0];
      irq_st_ff <= ev | (irq_st_ff
                 & ~({mpc_pkg::EV_W{wr_cl}} & wdata_in[mpc_pkg::EV_W-1:0]));
    end
  end
  assign irq_out = |(irq_st_ff & irq_en_ff);

  // read mux, answered one cycle after the strobe
  wire [7:0] ctrl_a = {rxc_ff, txc_ff, !tx_pend_ff, fe_ff,
                       2'b00, dbl_ff, afm_ff};
  wire [31:0] rd_mux =
      (addr_in == mpc_pkg::OFS_DATA)   ? {23'h0, rx_buf_ff} :
      (addr_in == mpc_pkg::OFS_CTRL_A) ? {24'h0, ctrl_a} :
      (addr_in == mpc_pkg::OFS_CTRL_B) ?
          {25'h0, csz_ff, stop2_ff, 2'b00, tx_ninth_bit_ff} :
      (addr_in == mpc_pkg::OFS_BAUD)   ? {{(32-BAUD_W){1'b0}}, baud_ff} :
      (addr_in == mpc_pkg::OFS_STATUS) ? {29'h0, irq_st_ff} :
      (addr_in == mpc_pkg::OFS_IRQ_EN) ? {29'h0, irq_en_ff} : 32'h0;
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_ff <= '0;
    else
      rdata_ff <= rd_in ? rd_mux : 32'h0;
  end
  assign rdata_out = rdata_ff;

  // checks
  filter_drop_a: assert property (@(posedge clock_in) disable iff (rst_in)
    rx_done && afm_ff && !rx_ftype |=> !rxc_ff || $past(rxc_ff))
    else $error("data frame kept while filtering");
  addr_keep_a: assert property (@(posedge clock_in) disable iff (rst_in)
    rx_done && rx_ftype |=> rxc_ff)
    else $error("address frame not flagged");
  open_keep_a: assert property (@(posedge clock_in) disable iff (rst_in)
    rx_done && !afm_ff |=> rxc_ff && rx_buf_ff == $past(rs_data))
    else $error("data frame lost with filter off");
  drop_buf_a: assert property (@(posedge clock_in) disable iff (rst_in)
    rx_done && afm_ff && !rx_ftype |=> $stable(rx_buf_ff))
    else $error("buffer written by filtered frame");
  tick_rate_a: assert property (@(posedge clock_in) disable iff (rst_in)
    tick && baud_ff == '0 |=> tick)
    else $error("divisor zero not full rate");
  tick_gap_a: assert property (@(posedge clock_in) disable iff (rst_in)
    tick && baud_ff == 1 && !wr_bd |=> !tick ##1 tick)
    else $error("divisor spacing wrong");
  type_sel_a: assert property (@(posedge clock_in) disable iff (rst_in)
    rx_done && is9 |-> rx_ftype == rs_sh_ff[8])
    else $error("ninth bit not frame type");
  tx_indep_a: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_data |=> tx_hold_ff[8] == $past(tx_ninth_bit_ff))
    else $error("ninth tx bit not taken");

endmodule

`default_nettype wire

// >>> serial_node.sv
// Purpose: far serial node that drives the receive line and reads tx
// Assumes: caller gives the bit time in clocks
// Notes:   line idles high (pulled up) between frames
`timescale 1ns/1ps
`default_nettype none

module serial_node (
  input  wire logic clock_in,
  input  wire logic txd_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // start, nine bits lsb first (ninth or first stop is the type), stops
  task automatic send(input logic [8:0] d, input int bt);
    line_out <= 1'b0;
    repeat (bt) @(posedge clock_in);
    for (int i = 0; i < 9; i++)
    begin
      line_out <= d[i];
      repeat (bt) @(posedge clock_in);
    end
    line_out <= 1'b1;
    repeat (2 * bt) @(posedge clock_in); // two stops
  endtask

  // mid-bit sampling: a wrong bit time drifts into neighbour bits
  task automatic recv(output logic [9:0] d, input int bt);
    int n;
    n = 0;
    while (txd_in !== 1'b0 && n < 20000)
    begin
      @(posedge clock_in);
      n++;
    end
    repeat (bt / 2) @(posedge clock_in);
    for (int i = 0; i < 10; i++)
    begin
      repeat (bt) @(posedge clock_in);
      d[i] = txd_in;
    end
  endtask
endmodule

`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench for the address-filtering serial block
// Assumes: divisor 0, so 16 clocks a bit (8 in double speed); one transmit uses divisor 1, 32 clocks a bit
// Notes:   register values are masked to the fields under test
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clock_in;
  logic        rst_in;
  logic        wr_in;
  logic        rd_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic [31:0] rdata;
  logic        rxd;
  logic        txd;
  logic        irq;
  logic [31:0] d;
  logic [9:0]  f;
  int          miscompares;
  int          checks_done;

  mpc_uart dut_u (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
    .rxd_in(rxd), .txd_out(txd), .irq_out(irq));
  serial_node node_u (.clock_in(clock_in), .txd_in(txd), .line_out(rxd));

  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask

  // one-cycle strobes, read data taken in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clock_in);
    wr_in <= 1'b0;
    #1; // let the written register settle before any check
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic end_sim();
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // reset values and an unmapped address
  task automatic t_reset();
    rd(mpc_pkg::OFS_CTRL_B);
    chk(d & 32'h70, 32'h30);
    rd(mpc_pkg::OFS_BAUD);
    chk(d, 32'h0);
    rd(8'h1c);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
  endtask

  // nine-bit address frame passes the filter and interrupts
  task automatic t_addr();
    wr(mpc_pkg::OFS_CTRL_B, 32'h70);
    wr(mpc_pkg::OFS_CTRL_A, 32'h1);
    wr(mpc_pkg::OFS_IRQ_EN, 32'h1);
    node_u.send(9'h15a, 16);
    rd(mpc_pkg::OFS_CTRL_A);
    chk(d & 32'h80, 32'h80);
    chk(32'(irq), 32'h1);
    rd(mpc_pkg::OFS_DATA);
    chk(d & 32'h1ff, 32'h15a);
    rd(mpc_pkg::OFS_STATUS);
    chk(d & 32'h1, 32'h1);
    wr(mpc_pkg::OFS_IRQ_CL, 32'h1);
    chk(32'(irq), 32'h0);
  endtask

  // data frame while filtering leaves no trace
  task automatic t_drop();
    node_u.send(9'h0a5, 16);
    rd(mpc_pkg::OFS_CTRL_A);
    chk(d & 32'h80, 32'h0);
    rd(mpc_pkg::OFS_STATUS);
    chk(d & 32'h1, 32'h0);
    chk(32'(irq), 32'h0);
  endtask

  // filter off: data kept; irq masked by the enable
  task automatic t_keep();
    wr(mpc_pkg::OFS_CTRL_A, 32'h0);
    wr(mpc_pkg::OFS_IRQ_EN, 32'h0);
    node_u.send(9'h03c, 16);
    chk(32'(irq), 32'h0);
    rd(mpc_pkg::OFS_DATA);
    chk(d & 32'h1ff, 32'h03c);
  endtask

  // transmit with the filter on: normal, then double speed, then normal at divisor 1
  task automatic t_tx(input logic [31:0] a, input logic [31:0] b,
                      input logic [7:0] v, input int bt);
    wr(mpc_pkg::OFS_CTRL_A, a);
    wr(mpc_pkg::OFS_CTRL_B, b);
    fork
      node_u.recv(f, bt);
      wr(mpc_pkg::OFS_DATA, {24'h0, v});
    join
    chk({22'h0, f}, {22'h0, 1'b1, b[0], v});
  endtask

  // eight-bit frames: first stop carries the type
  task automatic t_short();
    wr(mpc_pkg::OFS_CTRL_A, 32'h1);
    wr(mpc_pkg::OFS_CTRL_B, 32'h38);
    node_u.send(9'h142, 16);
    rd(mpc_pkg::OFS_DATA);
    chk(d & 32'hff, 32'h42);
    node_u.send(9'h024, 16);
    rd(mpc_pkg::OFS_CTRL_A);
    chk(d & 32'h80, 32'h0);
  endtask

  initial
  begin
    #2000000;
    miscompares++;
    end_sim();
  end

  initial
  begin
    miscompares = 0;
    checks_done = 0;
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_addr();
    t_drop();
    t_keep();
    t_tx(32'h1, 32'h71, 8'h81, 16);
    t_tx(32'h3, 32'h70, 8'h33, 8);
    wr(mpc_pkg::OFS_BAUD, 32'h1);
    t_tx(32'h1, 32'h71, 8'h5c, 32);
    wr(mpc_pkg::OFS_BAUD, 32'h0);
    t_short();
    end_sim();
  end
endmodule

`default_nettype wire
